// >>> dac_pkg.sv
package dac_pkg;

    // ------------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------------
    localparam int unsigned FRAME_BITS = 24;
    localparam int unsigned CODE_BITS  = 16;
    localparam int unsigned CNT_W      = 5;
    localparam int unsigned SEL_A_POS  = 16;
    localparam int unsigned SEL_B_POS  = 17;
    localparam logic [CNT_W-1:0] LAST_BIT  = 5'h17;
    localparam logic [15:0]      ZERO_CODE = 16'h0000;

    // ------------------------------------------------------------------
    // Link pin positions inside the sampled pin vector
    // ------------------------------------------------------------------
    localparam int unsigned PIN_W     = 5;
    localparam int unsigned PIN_FRAME = 0;
    localparam int unsigned PIN_SCLK  = 1;
    localparam int unsigned PIN_DIN   = 2;
    localparam int unsigned PIN_UPD   = 3;
    localparam int unsigned PIN_ZCL   = 4;
    localparam logic [4:0]  PIN_IDLE  = 5'h1b;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_MHZ            = 100;
    localparam int unsigned SCLK_MIN_PERIOD_NS = 20;
    localparam int unsigned SCLK_HALF_NS       = 80;
    localparam int unsigned SCLK_HALF_CYCLES   =
        (SCLK_HALF_NS * CLK_MHZ) / 1000;
    localparam int unsigned LINK_PULSE_NS      = 80;
    localparam int unsigned LINK_PULSE_CYCLES  =
        (LINK_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned TMR_W              = 8;

endpackage

// >>> dac_link_if.sv
`timescale 1ns/1ps
interface dac_link_if;

    // ------------------------------------------------------------------
    // Serial write port and control strobes, all driven by the host
    // ------------------------------------------------------------------
    logic frame_n;
    logic sclk;
    logic din;
    logic output_update_n;
    logic zero_clear_n;

    modport dev
    (
        input frame_n,
        input sclk,
        input din,
        input output_update_n,
        input zero_clear_n
    );

    modport host
    (
        output frame_n,
        output sclk,
        output din,
        output output_update_n,
        output zero_clear_n
    );

endinterface

// >>> dac_host.sv
`timescale 1ns/1ps
module dac_host
    import dac_pkg::*;
#(
    parameter int unsigned HALF_CYCLES  = SCLK_HALF_CYCLES,
    parameter int unsigned PULSE_CYCLES = LINK_PULSE_CYCLES
)
(
    // Clock and reset
    input  wire logic                  I_CLK,
    input  wire logic                  I_RESETN,
    // Frame request
    input  wire logic                  I_WR_VALID,
    input  wire logic [FRAME_BITS-1:0] I_WR_FRAME,
    output logic                       O_WR_READY,
    // Strobe requests
    input  wire logic                  I_UPDATE_PULSE,
    input  wire logic                  I_UPDATE_HOLD,
    input  wire logic                  I_CLEAR_PULSE,
    // Serial link
    dac_link_if.host                   LINK
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (HALF_CYCLES * 2 * 1000 / CLK_MHZ < SCLK_MIN_PERIOD_NS
        || HALF_CYCLES < 4 || HALF_CYCLES > 255)
        $error("HALF_CYCLES out of range");
    if (PULSE_CYCLES < 4 || PULSE_CYCLES > 255)
        $error("PULSE_CYCLES out of range");

    typedef enum logic [2:0]
    {
        H_IDLE = 3'b000,
        H_HIGH = 3'b001,
        H_LOW  = 3'b010,
        H_TAIL = 3'b011,
        H_GAP  = 3'b100
    } host_state_t;

    localparam logic [TMR_W-1:0] HALF_LAST  = TMR_W'(HALF_CYCLES - 1);
    localparam logic [TMR_W-1:0] PULSE_LEN  = TMR_W'(PULSE_CYCLES);

    host_state_t               state_q, state_d;
    logic [TMR_W-1:0]          tmr_q, tmr_d;
    logic [CNT_W-1:0]          bit_q, bit_d;
    logic [FRAME_BITS-1:0]     sh_q, sh_d;
    logic                      frame_n_q, frame_n_d;
    logic                      sclk_q, sclk_d;
    logic                      ready_q, ready_d;
    logic [TMR_W-1:0]          upd_tmr_q, upd_tmr_d;
    logic [TMR_W-1:0]          zcl_tmr_q, zcl_tmr_d;
    logic                      upd_n_q, upd_n_d;
    logic                      zcl_n_q, zcl_n_d;

    // ------------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------------
    always_comb
    begin
        state_d   = state_q;
        tmr_d     = tmr_q + 8'h01;
        bit_d     = bit_q;
        sh_d      = sh_q;
        frame_n_d = frame_n_q;
        sclk_d    = sclk_q;
        case (state_q)
            H_IDLE:
            begin
                tmr_d = '0;
                if (I_WR_VALID && ready_q)
                begin
                    sh_d      = I_WR_FRAME;
                    bit_d     = '0;
                    frame_n_d = 1'b0;
                    state_d   = H_HIGH;
                end
            end
            H_HIGH:
                if (tmr_q == HALF_LAST)
                begin
                    tmr_d   = '0;
                    sclk_d  = 1'b0;
                    state_d = H_LOW;
                end
            H_LOW:
                if (tmr_q == HALF_LAST)
                begin
                    tmr_d  = '0;
                    sclk_d = 1'b1;
                    if (bit_q == LAST_BIT)
                        state_d = H_TAIL;
                    else
                    begin
                        sh_d    = {sh_q[FRAME_BITS-2:0], 1'b0};
                        bit_d   = bit_q + 5'h01;
                        state_d = H_HIGH;
                    end
                end
            H_TAIL:
                if (tmr_q == HALF_LAST)
                begin
                    tmr_d     = '0;
                    frame_n_d = 1'b1;
                    state_d   = H_GAP;
                end
            H_GAP:
                if (tmr_q == HALF_LAST)
                    state_d = H_IDLE;
            default:
                state_d = H_IDLE;
        endcase
        ready_d = (state_d == H_IDLE);
    end

    // ------------------------------------------------------------------
    // Update and clear strobes
    // ------------------------------------------------------------------
    always_comb
    begin
        upd_tmr_d = upd_tmr_q;
        zcl_tmr_d = zcl_tmr_q;
        if (upd_tmr_q != '0)
            upd_tmr_d = upd_tmr_q - 8'h01;
        else if (I_UPDATE_PULSE)
            upd_tmr_d = PULSE_LEN;
        if (zcl_tmr_q != '0)
            zcl_tmr_d = zcl_tmr_q - 8'h01;
        else if (I_CLEAR_PULSE)
            zcl_tmr_d = PULSE_LEN;
        upd_n_d = !(I_UPDATE_HOLD || upd_tmr_d != '0);
        zcl_n_d = (zcl_tmr_d == '0);
    end

    always_ff @(posedge I_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            state_q   <= H_IDLE;
            tmr_q     <= '0;
            bit_q     <= '0;
            sh_q      <= '0;
            frame_n_q <= 1'b1;
            sclk_q    <= 1'b1;
            ready_q   <= 1'b1;
            upd_tmr_q <= '0;
            zcl_tmr_q <= '0;
            upd_n_q   <= 1'b1;
            zcl_n_q   <= 1'b1;
        end
        else
        begin
            state_q   <= state_d;
            tmr_q     <= tmr_d;
            bit_q     <= bit_d;
            sh_q      <= sh_d;
            frame_n_q <= frame_n_d;
            sclk_q    <= sclk_d;
            ready_q   <= ready_d;
            upd_tmr_q <= upd_tmr_d;
            zcl_tmr_q <= zcl_tmr_d;
            upd_n_q   <= upd_n_d;
            zcl_n_q   <= zcl_n_d;
        end
    end

    assign O_WR_READY           = ready_q;
    assign LINK.frame_n         = frame_n_q;
    assign LINK.sclk            = sclk_q;
    assign LINK.din             = sh_q[FRAME_BITS-1];
    assign LINK.output_update_n = upd_n_q;
    assign LINK.zero_clear_n    = zcl_n_q;

endmodule

// >>> dac_device.sv
`timescale 1ns/1ps
// Overview of operation
// - Update low copies input registers to outputs
// - Update held low still updates outputs
// - Clear zeroes the registers on its falling edge only
// - Update ignored while clear stays low
// - Clear zeroes all input and output registers
// - Clear mode ends at next frame's 24th edge
// - Clear during a frame aborts that frame
// - Frame select falling arms the shift register
// - One bit captured per falling clock edge
// - Early frame select rise discards partial frame
// - Twenty-four bit input shift register
// - Data sampled on serial clock falling edge
// - Host keeps serial clock at most 50 MHz
// - Codes are straight unsigned sixteen-bit binary
module dac_device
    import dac_pkg::*;
(
    // Clock and reset
    input  wire logic                 I_CLK,
    input  wire logic                 I_RESETN,
    // Serial link
    dac_link_if.dev                   LINK,
    // Converter codes
    output logic [CODE_BITS-1:0]      O_CODE_A,
    output logic [CODE_BITS-1:0]      O_CODE_B,
    // Status
    output logic                      O_CLEAR_MODE,
    output logic                      O_FRAME_DONE,
    output logic                      O_FRAME_ABORT
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (FRAME_BITS < CODE_BITS + 2 || (1 << CNT_W) < FRAME_BITS)
        $error("Frame layout does not fit");

    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_HOLD  = 2'b10
    } dev_state_t;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [PIN_W-1:0] meta_q, meta_d;
    logic [PIN_W-1:0] pin_q, pin_d;
    logic [PIN_W-1:0] prev_q, prev_d;

    always_comb
    begin
        meta_d = {LINK.zero_clear_n, LINK.output_update_n, LINK.din,
                  LINK.sclk, LINK.frame_n};
        pin_d  = meta_q;
        prev_d = pin_q;
    end

    always_ff @(posedge I_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            meta_q <= PIN_IDLE;
            pin_q  <= PIN_IDLE;
            prev_q <= PIN_IDLE;
        end
        else
        begin
            meta_q <= meta_d;
            pin_q  <= pin_d;
            prev_q <= prev_d;
        end
    end

    // ------------------------------------------------------------------
    // Edge detection on synchronised pins
    // ------------------------------------------------------------------
    logic frame_fall;
    logic frame_rise;
    logic sclk_fall;
    logic zcl_fall;
    logic din_s;
    logic upd_low;
    logic zcl_high;

    always_comb
    begin
        frame_fall = prev_q[PIN_FRAME] && !pin_q[PIN_FRAME];
        frame_rise = !prev_q[PIN_FRAME] && pin_q[PIN_FRAME];
        sclk_fall  = prev_q[PIN_SCLK] && !pin_q[PIN_SCLK];
        zcl_fall   = prev_q[PIN_ZCL] && !pin_q[PIN_ZCL];
        din_s      = pin_q[PIN_DIN];
        upd_low    = !pin_q[PIN_UPD];
        zcl_high   = pin_q[PIN_ZCL];
    end

    // ------------------------------------------------------------------
    // Frame receiver and register bank
    // ------------------------------------------------------------------
    dev_state_t             state_q, state_d;
    logic [CNT_W-1:0]       cnt_q, cnt_d;
    logic [FRAME_BITS-1:0]  shreg_q, shreg_d;
    logic [FRAME_BITS-1:0]  frame;
    logic [CODE_BITS-1:0]   in_a_q, in_a_d;
    logic [CODE_BITS-1:0]   in_b_q, in_b_d;
    logic [CODE_BITS-1:0]   dac_a_q, dac_a_d;
    logic [CODE_BITS-1:0]   dac_b_q, dac_b_d;
    logic                   zcl_mode_q, zcl_mode_d;
    logic                   done_q, done_d;
    logic                   abort_q, abort_d;

    always_comb
    begin
        state_d    = state_q;
        cnt_d      = cnt_q;
        shreg_d    = shreg_q;
        in_a_d     = in_a_q;
        in_b_d     = in_b_q;
        dac_a_d    = dac_a_q;
        dac_b_d    = dac_b_q;
        zcl_mode_d = zcl_mode_q;
        done_d     = 1'b0;
        abort_d    = 1'b0;
        frame      = {shreg_q[FRAME_BITS-2:0], din_s};

        if (zcl_fall)
        begin
            // Clear wins over everything, including a frame in flight
            state_d    = ST_IDLE;
            abort_d    = (state_q == ST_SHIFT);
            in_a_d     = ZERO_CODE;
            in_b_d     = ZERO_CODE;
            dac_a_d    = ZERO_CODE;
            dac_b_d    = ZERO_CODE;
            zcl_mode_d = 1'b1;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                    if (frame_fall)
                    begin
                        cnt_d   = '0;
                        shreg_d = '0;
                        state_d = ST_SHIFT;
                    end
                ST_SHIFT:
                    if (sclk_fall && cnt_q == LAST_BIT)
                    begin
                        // Last bit lands: the frame takes effect now
                        shreg_d    = frame;
                        done_d     = 1'b1;
                        zcl_mode_d = 1'b0;
                        if (frame[SEL_A_POS])
                            in_a_d = frame[CODE_BITS-1:0];
                        if (frame[SEL_B_POS])
                            in_b_d = frame[CODE_BITS-1:0];
                        state_d = frame_rise ? ST_IDLE : ST_HOLD;
                    end
                    else if (frame_rise)
                    begin
                        abort_d = 1'b1;
                        state_d = ST_IDLE;
                    end
                    else if (sclk_fall)
                    begin
                        shreg_d = frame;
                        cnt_d   = cnt_q + 5'h01;
                    end
                ST_HOLD:
                    // Further clocks are dropped until the next frame
                    if (frame_rise)
                        state_d = ST_IDLE;
                default:
                    state_d = ST_IDLE;
            endcase

            // Level copy serves both a pulse and a tied-low update pin
            if (upd_low && zcl_high)
            begin
                dac_a_d = in_a_q;
                dac_b_d = in_b_q;
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            state_q    <= ST_IDLE;
            cnt_q      <= '0;
            shreg_q    <= '0;
            in_a_q     <= ZERO_CODE;
            in_b_q     <= ZERO_CODE;
            dac_a_q    <= ZERO_CODE;
            dac_b_q    <= ZERO_CODE;
            zcl_mode_q <= 1'b0;
            done_q     <= 1'b0;
            abort_q    <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            shreg_q    <= shreg_d;
            in_a_q     <= in_a_d;
            in_b_q     <= in_b_d;
            dac_a_q    <= dac_a_d;
            dac_b_q    <= dac_b_d;
            zcl_mode_q <= zcl_mode_d;
            done_q     <= done_d;
            abort_q    <= abort_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign O_CODE_A      = dac_a_q;
    assign O_CODE_B      = dac_b_q;
    assign O_CLEAR_MODE  = zcl_mode_q;
    assign O_FRAME_DONE  = done_q;
    assign O_FRAME_ABORT = abort_q;

endmodule

// >>> dac_link_assertions.sv
`timescale 1ns/1ps
module dac_link_assertions
    import dac_pkg::*;
(
    // Clock and reset
    input wire logic                 I_CLK,
    input wire logic                 I_RESETN,
    // Link pins
    input wire logic                 frame_n,
    input wire logic                 sclk,
    input wire logic                 din,
    input wire logic                 output_update_n,
    input wire logic                 zero_clear_n,
    // Device outputs
    input wire logic [CODE_BITS-1:0] O_CODE_A,
    input wire logic [CODE_BITS-1:0] O_CODE_B,
    input wire logic                 O_CLEAR_MODE,
    input wire logic                 O_FRAME_DONE,
    input wire logic                 O_FRAME_ABORT
);
    // ---
    // Helper counters
    // ---
    logic [4:0] fcnt_q, fcnt_d;
    logic [2:0] quiet_q, quiet_d;
    logic [2:0] clo_q, clo_d;
    logic       sclk_q, frame_q;
    logic       zero_ab;

    assign zero_ab = (O_CODE_A == ZERO_CODE) && (O_CODE_B == ZERO_CODE);

    always_comb
    begin
        fcnt_d  = fcnt_q;
        quiet_d = 3'h0;
        clo_d   = 3'h0;
        if (frame_q && !frame_n)
            fcnt_d = 5'h00;
        else if (!frame_n && sclk_q && !sclk && fcnt_q != 5'h1f)
            fcnt_d = fcnt_q + 5'h01;
        if (output_update_n && zero_clear_n)
            quiet_d = (quiet_q == 3'h7) ? quiet_q : quiet_q + 3'h1;
        if (!zero_clear_n)
            clo_d = (clo_q == 3'h7) ? clo_q : clo_q + 3'h1;
    end

    always_ff @(posedge I_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            fcnt_q  <= 5'h00;
            quiet_q <= 3'h0;
            clo_q   <= 3'h0;
            sclk_q  <= 1'b1;
            frame_q <= 1'b1;
        end
        else
        begin
            fcnt_q  <= fcnt_d;
            quiet_q <= quiet_d;
            clo_q   <= clo_d;
            sclk_q  <= sclk;
            frame_q <= frame_n;
        end
    end

    // ---
    // Properties
    // ---
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESETN);

    a_din_stable: assert property ($fell(sclk) |-> $stable(din))
        else $error("din moved at sclk fall");
    a_frame_setup: assert property ($fell(frame_n) |-> sclk[*3])
        else $error("sclk fell too soon after frame start");
    a_frame_count: assert property ($rose(frame_n) |-> fcnt_q == 5'h18)
        else $error("frame did not carry 24 clocks");
    a_done_count: assert property (O_FRAME_DONE |-> fcnt_q == 5'h18)
        else $error("frame done before the 24th fall");
    a_done_exit: assert property (O_FRAME_DONE |-> !O_CLEAR_MODE)
        else $error("clear mode kept after complete frame");
    a_clear_zero: assert property ($fell(zero_clear_n) |->
        ##[1:30] (zero_ab && O_CLEAR_MODE))
        else $error("clear did not zero the codes");
    a_clear_blocks: assert property (clo_q >= 3'h6 |-> zero_ab)
        else $error("codes moved while clear low");
    a_quiet_hold: assert property (quiet_q == 3'h7 |->
        $stable(O_CODE_A) && $stable(O_CODE_B))
        else $error("codes moved without update strobe");
    a_abort_clear: assert property (
        ($fell(zero_clear_n) && !frame_n && fcnt_q < 5'h14)
        |-> ##[1:8] O_FRAME_ABORT)
        else $error("clear in frame gave no abort");

    c_done: cover property (O_FRAME_DONE);
    c_abort: cover property (O_FRAME_ABORT);
    c_clear: cover property ($rose(O_CLEAR_MODE));
endmodule

// >>> dual_dac_serial_load_clear_bench.sv
`timescale 1ns/1ps
module dual_dac_serial_load_clear_bench
    import dac_pkg::*;
;
    logic                  clk, rst_n, wr_valid, wr_ready;
    logic                  upd_pulse, upd_hold, zcl_pulse;
    logic [FRAME_BITS-1:0] wr_frame;
    logic [CODE_BITS-1:0]  code_a, code_b, code2_a, code2_b, v;
    logic [CODE_BITS-1:0]  a_m, b_m;
    logic                  clear_mode, done1, abort1, mode2, done2, abort2;
    logic [1:0]            expq[$];
    int                    errors, cmp_count, cyc;

    always #5 clk = ~clk;

    dac_link_if lnk();
    dac_link_if lnk2();

    dac_host dac_host_inst (.I_CLK(clk), .I_RESETN(rst_n),
        .I_WR_VALID(wr_valid), .I_WR_FRAME(wr_frame), .O_WR_READY(wr_ready),
        .I_UPDATE_PULSE(upd_pulse), .I_UPDATE_HOLD(upd_hold),
        .I_CLEAR_PULSE(zcl_pulse), .LINK(lnk));
    dac_device dac_device_inst (.I_CLK(clk), .I_RESETN(rst_n), .LINK(lnk),
        .O_CODE_A(code_a), .O_CODE_B(code_b), .O_CLEAR_MODE(clear_mode),
        .O_FRAME_DONE(done1), .O_FRAME_ABORT(abort1));
    dac_device dac_device_inst2 (.I_CLK(clk), .I_RESETN(rst_n), .LINK(lnk2),
        .O_CODE_A(code2_a), .O_CODE_B(code2_b), .O_CLEAR_MODE(mode2),
        .O_FRAME_DONE(done2), .O_FRAME_ABORT(abort2));
    dac_link_assertions dac_link_assertions_inst (.I_CLK(clk),
        .I_RESETN(rst_n), .frame_n(lnk.frame_n), .sclk(lnk.sclk),
        .din(lnk.din), .output_update_n(lnk.output_update_n),
        .zero_clear_n(lnk.zero_clear_n), .O_CODE_A(code_a),
        .O_CODE_B(code_b), .O_CLEAR_MODE(clear_mode),
        .O_FRAME_DONE(done1), .O_FRAME_ABORT(abort1));

    // ---
    // Tasks
    // ---
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask

    task step(input int n);
        repeat (n) @(posedge clk);
    endtask

    task issue(input logic [23:0] f, input logic ab);
        @(posedge clk);
        wr_valid <= 1'b1;
        wr_frame <= f;
        expq.push_back({1'b0, ab});
        @(posedge clk);
        wr_valid <= 1'b0;
        #1 chk(wr_ready, 1'b0);
    endtask

    task idle;
        do
        begin
            @(posedge clk);
            #1;
        end
        while (wr_ready !== 1'b1);
    endtask

    // Rule-breaking far end on the second link
    task raw(input logic [25:0] bits, input int n);
        lnk2.frame_n <= 1'b0;
        step(8);
        for (int i = 0; i < n; i++)
        begin
            lnk2.din <= bits[25-i];
            step(8);
            lnk2.sclk <= 1'b0;
            step(8);
            lnk2.sclk <= 1'b1;
        end
        step(8);
        lnk2.frame_n <= 1'b1;
        lnk2.din <= ~lnk2.din;
        step(8);
    endtask

    task wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge clk)
    begin
        if (rst_n === 1'b1 && (done1 | abort1 | done2 | abort2) === 1'b1)
            chk({done2 | abort2, abort1 | abort2}, (expq.size() > 0) ?
                {38'h0, expq.pop_front()} : 40'hff);
    end

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors++;
            wrap_up();
        end
    end

    // ---
    // Tests
    // ---
    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        {wr_valid, wr_frame, upd_pulse, upd_hold, zcl_pulse} = '0;
        {lnk2.frame_n, lnk2.sclk, lnk2.din} = 3'h6;
        lnk2.output_update_n = 1'b0;
        lnk2.zero_clear_n = 1'b1;
        {errors, cmp_count, cyc, a_m, b_m} = '0;
        void'($urandom(32'hb3b9));
        step(4);
        rst_n <= 1'b1;
        step(4);
        upd_hold <= 1'b1;
        for (int k = 0; k < 8; k++)
        begin
            v = (k == 3) ? 16'hffff : (k == 5) ? 16'h0000 : 16'($urandom);
            issue({6'($urandom), 2'(k), v}, 1'b0);
            idle();
            if (k[0]) a_m = v;
            if (k[1]) b_m = v;
            chk({code_a, code_b}, {a_m, b_m});
        end
        $display("test held update done");
        step(1);
        upd_hold <= 1'b0;
        issue({8'h01, ~a_m}, 1'b0);
        idle();
        issue({8'h02, ~b_m}, 1'b0);
        idle();
        chk({code_a, code_b}, {a_m, b_m});
        step(1);
        upd_pulse <= 1'b1;
        step(1);
        upd_pulse <= 1'b0;
        step(12);
        chk({code_a, code_b}, {~a_m, ~b_m});
        $display("test pulsed update done");
        upd_hold <= 1'b1;
        issue({8'h03, 16'h5a5a}, 1'b1);
        step(100);
        zcl_pulse <= 1'b1;
        step(1);
        zcl_pulse <= 1'b0;
        idle();
        chk({clear_mode, code_a, code_b}, {1'b1, ZERO_CODE, ZERO_CODE});
        issue({8'h01, 16'hc3c3}, 1'b0);
        step(200);
        chk(clear_mode, 1'b1);
        idle();
        chk({clear_mode, code_a, code_b}, {1'b0, 16'hc3c3, ZERO_CODE});
        $display("test clear done");
        step(1);
        expq.push_back(2'b11);
        raw(26'($urandom), 10);
        chk({code2_a, code2_b}, 32'h0);
        v = 16'($urandom);
        expq.push_back(2'b10);
        raw({8'h03, v, 2'b11}, 26);
        chk({mode2, code2_a, code2_b}, {1'b0, v, v});
        $display("test far end frames done");
        step(10);
        chk(expq.size(), 0);
        wrap_up();
    end
endmodule
